// ---- hw/cdp_pkg.sv ----
// Purpose: shared constants, types and helpers of the codec digital datapath
// Assumes: one sample uses 16 of the 32 frame slots, two samples per frame
// Notes:
package cdp_pkg;
   localparam int CDP_APB_AW = 12;
   localparam logic [11:0] CDP_ADDR_CTRL = 12'h000;
   localparam logic [11:0] CDP_ADDR_STATUS = 12'h004;
   localparam logic [8:0] CDP_BITCNT_RESET = 9'h1ff;
   localparam logic [3:0] CDP_SLOT_CTRL = 4'h0;
   localparam logic [3:0] CDP_SLOT_LPLAY = 4'h1;
   localparam logic [3:0] CDP_SLOT_RPLAY = 4'h2;
   localparam logic [3:0] CDP_SLOT_TX_SHARED = 4'h3;
   localparam logic [3:0] CDP_SLOT_TX_LAST = 4'h5;
   localparam int CDP_CW_CLEAR_OVERRANGE = 15;
   localparam int CDP_CW_MCE = 14;
   localparam int CDP_CW_READ_REQUEST = 13;
   localparam logic [15:0] CDP_CW_RESET = 16'hc000;
   localparam logic [7:0] CDP_IX_RESET = 8'h00;
   localparam logic [3:0] CDP_IX_LGAIN = 4'h0;
   localparam logic [3:0] CDP_IX_RGAIN = 4'h1;
   localparam logic [3:0] CDP_IX_AUX = 4'h2;
   localparam logic [3:0] CDP_IX_LDAC = 4'h6;
   localparam logic [3:0] CDP_IX_RDAC = 4'h7;
   localparam logic [3:0] CDP_IX_FORMAT = 4'h8;
   localparam logic [3:0] CDP_IX_HOLE = 4'hb;
   localparam logic [3:0] CDP_IX_MISC = 4'hc;
   localparam logic [3:0] CDP_IX_MONITOR = 4'hd;
   localparam logic [3:0] CDP_IX_LAST = 4'hd;
   localparam int CDP_ZC_TIMEOUT = 384;
   localparam logic [15:0] CDP_POS_FULL = 16'h7fff;
   localparam logic [15:0] CDP_NEG_FULL = 16'h8000;

   typedef enum logic [1:0] {
      CDP_FMT_LIN16 = 2'h0,
      CDP_FMT_LIN8 = 2'h1,
      CDP_FMT_MULAW = 2'h2,
      CDP_FMT_ALAW = 2'h3
   } cdp_format_type;

   // 1.5 dB steps: fraction for att[1:0], 6.02 dB shifts for att[5:2]
   function automatic logic [15:0] cdpAttenuate(input logic [15:0] x,
                                                input logic [5:0] att);
      logic [16:0] frac;
      logic signed [33:0] p;
      case (att[1:0])
         2'h1: frac = 17'h0d766;
         2'h2: frac = 17'h0b53c;
         2'h3: frac = 17'h0987d;
         default: frac = 17'h10000;
      endcase
      p = $signed(x) * $signed({1'b0, frac});
      p = p >>> (16 + int'(att[5:2]));
      return p[15:0];
   endfunction
endpackage

// ---- hw/cdp_law_codec.sv ----
// Purpose: mu-law and A-law expansion and compression of one channel
// Assumes: law selects A-law when high, mu-law when low
// Notes: purely combinational
`timescale 1ns/100ps
module cdp_law_codec (
   // control
   input logic law,
   // compress path
   input logic [15:0] linIn,
   output logic [7:0] codeOut,
   // expand path
   input logic [7:0] codeIn,
   output logic [15:0] linOut
);
   import cdp_pkg::*;

   function automatic logic [15:0] muExpand(input logic [7:0] c);
      logic [7:0] u;
      logic [15:0] t;
      u = ~c;
      t = {9'h000, u[3:0], 3'h0} + 16'h0084;
      t = (t << u[6:4]) - 16'h0084;
      return u[7] ? 16'h0000 - t : t;
   endfunction

   function automatic logic [15:0] aExpand(input logic [7:0] c);
      logic [7:0] a;
      logic [15:0] t;
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) t = t + 16'h0008;
      else t = (t + 16'h0108) << (a[6:4] - 3'h1);
      return a[7] ? t : 16'h0000 - t;
   endfunction

   function automatic logic [7:0] muCompress(input logic [15:0] x);
      logic [15:0] m;
      logic [7:0] mask;
      logic [2:0] seg;
      m = x[15] ? 16'h0000 - x : x;
      mask = x[15] ? 8'h7f : 8'hff;
      if (m > 16'h7f7b) m = 16'h7f7b; // clip keeps the bias inside 15 bits
      m = m + 16'h0084;
      seg = 3'h0;
      for (int i = 0; i < 8; i++) if (m[i + 7]) seg = 3'(i);
      m = m >> ({1'b0, seg} + 4'h3);
      return {1'b0, seg, m[3:0]} ^ mask;
   endfunction

   function automatic logic [7:0] aCompress(input logic [15:0] x);
      logic [15:0] m;
      logic [7:0] mask;
      logic [2:0] seg;
      m = (x[15] ? ~x : x) >> 3;
      mask = x[15] ? 8'h55 : 8'hd5;
      seg = 3'h0;
      for (int i = 5; i < 12; i++) if (m[i]) seg = 3'(i - 4);
      m = (seg < 3'h2) ? m >> 1 : m >> seg;
      return {1'b0, seg, m[3:0]} ^ mask;
   endfunction

   // telephony tables, results scaled to the top of the 16-bit word
   always_comb begin
      linOut = law ? aExpand(codeIn) : muExpand(codeIn);
      codeOut = law ? aCompress(linIn) : muCompress(linIn);
   end
endmodule

// ---- hw/cdp_zc_atten.sv ----
// Purpose: playback attenuator of one channel with zero-crossing change
// Assumes: sampleStrobe pulses once per sample
// Notes: a changed target waits for a sign change or the timeout
`timescale 1ns/100ps
module cdp_zc_atten #(
   parameter int TIMEOUT = cdp_pkg::CDP_ZC_TIMEOUT
) (
   // clock and reset
   input logic mclk,
   input logic rst,
   // sample in
   input logic sampleStrobe,
   input logic [15:0] sampleIn,
   // requested setting
   input logic [5:0] targetAtt,
   input logic targetMute,
   // result
   output logic [15:0] sampleOut,
   output logic changePending
);
   import cdp_pkg::*;

   localparam logic [8:0] TMO_LAST = 9'(TIMEOUT - 1);
   logic [6:0] cur_reg, lastTgt_reg, tgt, useAtt;
   logic prevSign_reg, apply, zeroCross, timedOut;
   logic [8:0] timer_reg;
   logic [15:0] sampleOut_reg;

   assign tgt = {targetMute, targetAtt};
   assign changePending = (tgt != cur_reg);
   assign zeroCross = (sampleIn[15] != prevSign_reg);
   assign timedOut = (timer_reg >= TMO_LAST);
   assign apply = changePending & (zeroCross | timedOut);
   assign useAtt = apply ? tgt : cur_reg;
   assign sampleOut = sampleOut_reg;

   // setting and output move only on a sample
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cur_reg <= 7'h40; // comes up muted, as mode change is set after reset
         prevSign_reg <= 1'b0;
         sampleOut_reg <= 16'h0000;
      end else if (sampleStrobe) begin
         prevSign_reg <= sampleIn[15];
         if (apply) cur_reg <= tgt;
         sampleOut_reg <= useAtt[6] ? 16'h0000 : cdpAttenuate(sampleIn, useAtt[5:0]);
      end
   end

   // timeout counts samples since the newest request
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lastTgt_reg <= 7'h40;
         timer_reg <= 9'h000;
      end else begin
         lastTgt_reg <= tgt;
         if (tgt != lastTgt_reg) timer_reg <= 9'h000;
         else if (sampleStrobe & apply) timer_reg <= 9'h000;
         else if (sampleStrobe & changePending & ~timedOut) timer_reg <= timer_reg + 9'h001;
      end
   end
endmodule

// ---- hw/cdp_datapath.sv ----
// Purpose: TDM serial port, control words and digital datapath of the codec
// Assumes: serial clock and frame sync come from the bus master
// Notes: frame sync marks the first bit of a 32-slot frame
`timescale 1ns/100ps
module cdp_datapath #(
   parameter logic [3:0] CHIP_ID = 4'h5, // arbitrary value
   parameter int ZC_TIMEOUT = cdp_pkg::CDP_ZC_TIMEOUT
) (
   // clock and reset
   input logic mclk,
   input logic rst,
   // apb slave
   input logic [cdp_pkg::CDP_APB_AW-1:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input logic serialClk,
   input logic frameSync,
   input logic serialIn,
   output logic serialOut,
   output logic serialOutEn,
   // converters
   input logic [15:0] adcLeft,
   input logic [15:0] adcRight,
   input logic [1:0] ovrLeft,
   input logic [1:0] ovrRight,
   output logic [15:0] dacLeft,
   output logic [15:0] dacRight,
   output logic dacStrobe,
   // analog and clock controls
   output logic [3:0] pgaGainLeft,
   output logic [3:0] pgaGainRight,
   output logic [5:0] auxOneLeft,
   output logic [5:0] auxOneRight,
   output logic [5:0] auxTwoLeft,
   output logic [5:0] auxTwoRight,
   output logic crystalSelect,
   output logic [2:0] rateSelect,
   output logic monoMode
);
   import cdp_pkg::*;

   // link sampling
   logic [2:0] clkSync_reg;
   logic [1:0] fsSync_reg;
   logic [1:0] sdiSync_reg;
   logic sclkRise, sclkFall;

   // frame position and receive
   logic [8:0] bitCnt_reg, bitCnt_next, txBit;
   logic [15:0] rxShift_reg, rxWord;
   logic [3:0] rxSlot, txSlot;
   logic wordDone, ctrlDone;

   // control word and index registers
   logic [15:0] ctrlWord_reg;
   logic [7:0] idx_reg [16];
   logic clear_overrange, mode_change_enable, read_request;
   logic [3:0] rbAddr;
   cdp_format_type fmt;

   // datapath
   logic [15:0] playL_reg, playR_reg, capL_reg, capR_reg;
   logic sampleStrobe_reg, dacStrobe_reg;
   logic [15:0] linL, linR, lawLinL, lawLinR, monL, monR, mixL, mixR;
   logic [7:0] codeL, codeR;
   logic [1:0] ovrL_reg, ovrR_reg;
   logic pendL, pendR;

   // transmit
   logic [15:0] txShift_reg, txWord, statusWord, rbWord;
   logic txEn_reg, txOn, slotSelect_reg;
   logic [1:0] txSel;

   // apb
   logic [31:0] prdata_reg;
   logic apbHit;

   // invalid index addresses neither write nor read back
   function automatic logic ixValid(input logic [3:0] a);
      return (a != CDP_IX_HOLE) && (a <= CDP_IX_LAST);
   endfunction

   // port word to internal linear
   function automatic logic [15:0] toLinear(input cdp_format_type f,
                                            input logic [15:0] w,
                                            input logic [15:0] lawLin);
      case (f)
         CDP_FMT_LIN8: toLinear = {~w[15], w[14:8], 8'h00};
         CDP_FMT_MULAW, CDP_FMT_ALAW: toLinear = lawLin;
         default: toLinear = w;
      endcase
   endfunction

   // internal linear to port word
   function automatic logic [15:0] toWord(input cdp_format_type f,
                                          input logic [15:0] lin,
                                          input logic [7:0] code);
      case (f)
         CDP_FMT_LIN8: toWord = {~lin[15], lin[14:8], 8'h00};
         CDP_FMT_MULAW, CDP_FMT_ALAW: toWord = {code, 8'h00};
         default: toWord = lin;
      endcase
   endfunction

   // monitor plus playback clipped, never wrapped
   function automatic logic [15:0] satAdd(input logic [15:0] a,
                                          input logic [15:0] b);
      logic [16:0] s;
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) return s[16] ? CDP_NEG_FULL : CDP_POS_FULL;
      return s[15:0];
   endfunction

   // two flops on frame sync and data, three on the clock; clock edges compare its second and third stages
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clkSync_reg <= 3'h0;
         fsSync_reg <= 2'h0;
         sdiSync_reg <= 2'h0;
      end else begin
         clkSync_reg <= {clkSync_reg[1:0], serialClk};
         fsSync_reg <= {fsSync_reg[0], frameSync};
         sdiSync_reg <= {sdiSync_reg[0], serialIn};
      end
   end

   // data is taken on the falling serial edge, driven on the rising one
   assign sclkRise = clkSync_reg[1] & ~clkSync_reg[2];
   assign sclkFall = ~clkSync_reg[1] & clkSync_reg[2];

   // 512-bit frame counter; frame sync restarts it at bit 0
   assign bitCnt_next = fsSync_reg[1] ? 9'h000 : bitCnt_reg + 9'h001;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) bitCnt_reg <= CDP_BITCNT_RESET;
      else if (sclkFall) bitCnt_reg <= bitCnt_next;
   end

   // msb-first receive shifter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rxShift_reg <= 16'h0000;
      else if (sclkFall) rxShift_reg <= rxWord;
   end
   assign rxWord = {rxShift_reg[14:0], sdiSync_reg[1]};

   // slot number inside the sample, both halves of a frame alike
   assign rxSlot = bitCnt_next[7:4];
   assign wordDone = sclkFall && (bitCnt_next[3:0] == 4'hf);
   assign ctrlDone = wordDone && (rxSlot == CDP_SLOT_CTRL);

   // latest control word; readback and clear bit come from it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) ctrlWord_reg <= CDP_CW_RESET;
      else if (ctrlDone) ctrlWord_reg <= rxWord;
   end
   assign clear_overrange = ctrlWord_reg[CDP_CW_CLEAR_OVERRANGE];
   assign mode_change_enable = ctrlWord_reg[CDP_CW_MCE];
   assign read_request = ctrlWord_reg[CDP_CW_READ_REQUEST];
   assign rbAddr = ctrlWord_reg[11:8];

   // index write; format and misc need mode change set in the same word
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) idx_reg[i] <= CDP_IX_RESET;
      end else if (ctrlDone && !rxWord[CDP_CW_READ_REQUEST] && ixValid(rxWord[11:8])) begin
         if (rxWord[CDP_CW_MCE] ||
             (rxWord[11:8] != CDP_IX_FORMAT && rxWord[11:8] != CDP_IX_MISC))
            idx_reg[rxWord[11:8]] <= rxWord[7:0];
      end
   end

   // settings taken from index registers
   assign fmt = cdp_format_type'(idx_reg[CDP_IX_FORMAT][6:5]);
   assign monoMode = idx_reg[CDP_IX_FORMAT][4];
   assign rateSelect = idx_reg[CDP_IX_FORMAT][3:1];
   assign crystalSelect = idx_reg[CDP_IX_FORMAT][0]; // reset gives crystal_one
   assign pgaGainLeft = idx_reg[CDP_IX_LGAIN][3:0];
   assign pgaGainRight = idx_reg[CDP_IX_RGAIN][3:0];
   // bit 5 mutes, bits 4:0 give 32 gain steps
   assign auxOneLeft = {idx_reg[CDP_IX_AUX][7], idx_reg[CDP_IX_AUX][4:0]};
   assign auxOneRight = {idx_reg[CDP_IX_AUX + 4'h1][7], idx_reg[CDP_IX_AUX + 4'h1][4:0]};
   assign auxTwoLeft = {idx_reg[CDP_IX_AUX + 4'h2][7], idx_reg[CDP_IX_AUX + 4'h2][4:0]};
   assign auxTwoRight = {idx_reg[CDP_IX_AUX + 4'h3][7], idx_reg[CDP_IX_AUX + 4'h3][4:0]};

   // playback words held until the right word completes the sample
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         playL_reg <= 16'h0000;
         playR_reg <= 16'h0000;
         sampleStrobe_reg <= 1'b0;
      end else begin
         if (wordDone && rxSlot == CDP_SLOT_LPLAY) playL_reg <= rxWord;
         if (wordDone && rxSlot == CDP_SLOT_RPLAY) playR_reg <= rxWord;
         sampleStrobe_reg <= wordDone && (rxSlot == CDP_SLOT_RPLAY);
      end
   end

   // conversion only at the port edges
   cdp_law_codec u_codec_left (
      .law(fmt == CDP_FMT_ALAW),
      .linIn(capL_reg),
      .codeOut(codeL),
      .codeIn(playL_reg[15:8]),
      .linOut(lawLinL)
   );
   cdp_law_codec u_codec_right (
      .law(fmt == CDP_FMT_ALAW),
      .linIn(capR_reg),
      .codeOut(codeR),
      .codeIn(playR_reg[15:8]),
      .linOut(lawLinR)
   );

   // mono plays the left sample on both channels
   assign linL = toLinear(fmt, playL_reg, lawLinL);
   assign linR = monoMode ? linL : toLinear(fmt, playR_reg, lawLinR);

   // monitor taps a copy; the capture registers keep the raw value
   always_comb begin
      monL = 16'h0000;
      monR = 16'h0000;
      if (idx_reg[CDP_IX_MONITOR][0]) begin // enable bit; low stops mixing
         monL = cdpAttenuate(adcLeft, idx_reg[CDP_IX_MONITOR][7:2]);
         monR = cdpAttenuate(monoMode ? adcLeft : adcRight, idx_reg[CDP_IX_MONITOR][7:2]);
      end
   end
   assign mixL = satAdd(linL, monL);
   assign mixR = satAdd(linR, monR);

   // mode change mutes the playback attenuators
   cdp_zc_atten #(
      .TIMEOUT(ZC_TIMEOUT)
   ) u_atten_left (
      .mclk(mclk),
      .rst(rst),
      .sampleStrobe(sampleStrobe_reg),
      .sampleIn(mixL),
      .targetAtt(idx_reg[CDP_IX_LDAC][5:0]),
      .targetMute(idx_reg[CDP_IX_LDAC][7] | mode_change_enable),
      .sampleOut(dacLeft),
      .changePending(pendL)
   );
   cdp_zc_atten #(
      .TIMEOUT(ZC_TIMEOUT)
   ) u_atten_right (
      .mclk(mclk),
      .rst(rst),
      .sampleStrobe(sampleStrobe_reg),
      .sampleIn(mixR),
      .targetAtt(idx_reg[CDP_IX_RDAC][5:0]),
      .targetMute(idx_reg[CDP_IX_RDAC][7] | mode_change_enable),
      .sampleOut(dacRight),
      .changePending(pendR)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) dacStrobe_reg <= 1'b0;
      else dacStrobe_reg <= sampleStrobe_reg;
   end
   assign dacStrobe = dacStrobe_reg;

   // capture and overrange move once per sample
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         capL_reg <= 16'h0000;
         capR_reg <= 16'h0000;
         ovrL_reg <= 2'h0;
         ovrR_reg <= 2'h0;
      end else if (sampleStrobe_reg) begin
         capL_reg <= adcLeft; // no mix here
         capR_reg <= monoMode ? adcLeft : adcRight;
         // clear bit high follows each sample, low keeps the largest
         if (clear_overrange || ovrLeft > ovrL_reg) ovrL_reg <= ovrLeft;
         if (clear_overrange || ovrRight > ovrR_reg) ovrR_reg <= ovrRight;
      end
   end

   // status, or readback in control word layout
   assign statusWord = {2'b00, read_request, 1'b0, CHIP_ID, 2'b00, ovrR_reg, ovrL_reg, 2'b00};
   assign rbWord = {ctrlWord_reg[15:8], idx_reg[rbAddr]};

   // next bit to present belongs to the coming falling edge
   assign txBit = bitCnt_reg + 9'h001;
   assign txSlot = txBit[7:4];
   // separate wires send in slots 0-2, shared wire in slots 3-5
   assign txOn = slotSelect_reg ? (txSlot <= CDP_SLOT_RPLAY)
                 : (txSlot >= CDP_SLOT_TX_SHARED && txSlot <= CDP_SLOT_TX_LAST);
   assign txSel = slotSelect_reg ? txSlot[1:0] : 2'(txSlot - CDP_SLOT_TX_SHARED);

   // old request still stands at slot 0, so readback lands a sample later
   always_comb begin
      case (txSel)
         2'h0: txWord = (read_request && ixValid(rbAddr)) ? rbWord : statusWord;
         2'h1: txWord = toWord(fmt, capL_reg, codeL);
         2'h2: txWord = toWord(fmt, capR_reg, codeR);
         default: txWord = 16'h0000;
      endcase
   end

   // transmit shifter and output enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txShift_reg <= 16'h0000;
         txEn_reg <= 1'b0;
      end else if (sclkRise) begin
         txEn_reg <= txOn;
         if (txOn && txBit[3:0] == 4'h0) txShift_reg <= txWord;
         else txShift_reg <= {txShift_reg[14:0], 1'b0};
      end
   end
   assign serialOut = txShift_reg[15];
   assign serialOutEn = txEn_reg;

   // apb: zero wait states, unmapped access flags an error
   assign apbHit = (paddr == CDP_ADDR_CTRL) || (paddr == CDP_ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~apbHit;
   assign prdata = prdata_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) slotSelect_reg <= 1'b0;
      else if (psel && penable && pwrite && paddr == CDP_ADDR_CTRL) slotSelect_reg <= pwdata[0];
   end

   // read data captured in the setup cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            CDP_ADDR_CTRL: prdata_reg <= {31'h00000000, slotSelect_reg};
            CDP_ADDR_STATUS: prdata_reg <= {22'h000000, monoMode, pendR, pendL, crystalSelect,
                                           clear_overrange, mode_change_enable, ovrR_reg, ovrL_reg};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end
endmodule

// ---- bench/cdp_datapath_checker.sv ----
// Purpose: port checks of the codec datapath
// Assumes: one clock domain, rst active high
// Notes: bound onto every datapath instance
`timescale 1ns/100ps
module cdp_datapath_checker (
   // clock and reset
   input logic mclk,
   input logic rst,
   // apb
   input logic [cdp_pkg::CDP_APB_AW-1:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // datapath
   input logic [15:0] dacLeft,
   input logic [15:0] dacRight,
   input logic dacStrobe,
   input logic crystalSelect
);
   import cdp_pkg::*;
   logic access;
   logic mapped;
   // access phase and decode, shared by the bus checks
   assign access = psel && penable;
   assign mapped = paddr == CDP_ADDR_CTRL || paddr == CDP_ADDR_STATUS;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_ready_high: assert property (access |-> pready) else $error("no ready");
   a_unmapped_err: assert property (access && !mapped |-> pslverr) else $error("no err");
   a_mapped_ok: assert property (access && mapped |-> !pslverr) else $error("bad err");
   a_err_in_access: assert property (pslverr |-> access) else $error("stray err");
   a_read_holds: assert property (access && !pwrite |=> $stable(prdata)) else $error("rd moved");
   a_strobe_spaced: assert property (dacStrobe |=> !dacStrobe [*8]) else $error("strobe");
   // a new dac value may only appear together with its sample strobe
   a_dac_at_strobe: assert property ($changed(dacLeft) || $changed(dacRight) |-> dacStrobe)
      else $error("dac moved");
   a_crystal_default: assert property ($past(rst) |-> !crystalSelect) else $error("crystal");
   c_unmapped: cover property (access && !mapped);
   c_strobe: cover property (dacStrobe);
   c_crystal_two: cover property (crystalSelect);
endmodule

bind cdp_datapath cdp_datapath_checker cdp_datapath_checker_i (.mclk, .rst, .paddr, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .dacLeft, .dacRight, .dacStrobe, .crystalSelect);

// ---- bench/cdp_host_port.sv ----
// Purpose: host serial port model, frame of 32 slots of 16 bits
// Assumes: link clock runs free, 160 ns period
// Notes: sends slots 0-2, collects slots 0-5 of each sample
`timescale 1ns/100ps
module cdp_host_port (
   // words to send
   input logic [15:0] tx [0:2],
   // link
   output logic serialClk,
   output logic frameSync,
   output logic serialIn,
   input logic serialOut,
   // words seen
   output logic [15:0] rx [0:5],
   output int nSamples
);
   logic [8:0] bitNo;
   logic [15:0] sh;
   // launch on the rise, sample on the fall
   initial begin
      {serialClk, frameSync, serialIn, bitNo, sh, nSamples} = '0;
      forever begin
         #80 serialClk = 1;
         frameSync = bitNo == 9'h0;
         // idle slots toggle so a stale level never passes for data
         serialIn = bitNo[7:4] < 3 ? tx[bitNo[7:4]][~bitNo[3:0]] : bitNo[0];
         #80 serialClk = 0;
         sh = {sh[14:0], serialOut};
         if (bitNo[3:0] == 4'hf && bitNo[7:4] < 6) rx[bitNo[7:4]] = sh;
         if (bitNo[7:0] == 8'h5f) nSamples++;
         bitNo++;
      end
   end
endmodule

// ---- bench/test_codec_tdm_digital_datapath.sv ----
// Purpose: self-checking bench of the codec datapath
// Assumes: host port model on the link, APB tasks here
// Notes: short zero-crossing timeout keeps the run brief
`timescale 1ns/100ps
module test_codec_tdm_digital_datapath;
   import cdp_pkg::*;
   localparam logic [3:0] ID = 4'h9; // arbitrary value
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic serialClk, frameSync, serialIn, serialOut, crystalSelect, monoMode, dacStrobe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adcLeft, adcRight, dacLeft, dacRight;
   logic [15:0] tx [0:2];
   logic [15:0] rx [0:5];
   logic [1:0] ovrLeft, ovrRight;
   logic [2:0] rateSelect;
   int nSamples, nErrors, nTests;
   cdp_datapath #(.CHIP_ID(ID), .ZC_TIMEOUT(4)) cdp_datapath_i (.mclk, .rst, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .serialClk, .frameSync,
      .serialIn, .serialOut, .serialOutEn(), .adcLeft, .adcRight, .ovrLeft, .ovrRight,
      .dacLeft, .dacRight, .dacStrobe, .pgaGainLeft(), .pgaGainRight(), .auxOneLeft(),
      .auxOneRight(), .auxTwoLeft(), .auxTwoRight(), .crystalSelect, .rateSelect, .monoMode);
   cdp_host_port cdp_host_port_i (.tx, .serialClk, .frameSync, .serialIn, .serialOut, .rx,
      .nSamples);
   task automatic giveVerdict;
      $display("mismatches %0d of %0d checks", nErrors, nTests);
      if (nErrors == 0 && nTests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // entered just after a rising edge; holds the request until ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      for (k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (k == 20) begin
         nErrors++;
         giveVerdict;
      end
      @(posedge mclk);
   endtask
   // new control word, then let whole samples pass
   task automatic step(input logic [15:0] c, input int n);
      int k, s;
      tx[0] = c;
      s = nSamples + n;
      for (k = 0; k < 3000 * n && nSamples < s; k++) @(posedge mclk);
      if (nSamples < s) begin
         nErrors++;
         giveVerdict;
      end
   endtask
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      {nErrors, nTests, psel, penable, pwrite, paddr, pwdata, ovrLeft, ovrRight} = '0;
      rst = 1;
      adcLeft = 16'h1234;
      adcRight = 16'h5678;
      tx = '{16'hc000, 16'h0000, 16'h0000};
      repeat (2) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      apb(0, CDP_ADDR_STATUS, 0); check("status reg", 32'h30, rd);
      ovrLeft <= 2'h1;
      ovrRight <= 2'h2;
      step(16'hc000, 3);
      check("status slot", {4'h0, ID, 8'h24}, rx[3]);
      apb(0, CDP_ADDR_STATUS, 0); check("ovr reg", 32'h39, rd);
      step(16'h4831, 2);
      check("crystal", 1, crystalSelect);
      check("mono", 1, monoMode);
      step(16'h6800, 2);
      check("readback", 16'h6831, rx[3]);
      check("left capture", 16'h9200, rx[4]);
      check("right capture", 16'h9200, rx[5]);
      tx[1] = 16'h40ab;
      tx[2] = 16'h7f00;
      step(16'h0000, 8);
      check("dac left", 16'hc000, dacLeft);
      check("dac right", 16'hc000, dacRight);
      tx[1] = 16'hff00;
      step(16'h0d01, 2);
      check("mix clip", CDP_POS_FULL, dacLeft);
      apb(1, CDP_ADDR_CTRL, 1);
      apb(0, CDP_ADDR_CTRL, 0); check("ctrl reg", 1, rd);
      step(16'h2800, 3);
      check("readback two wire", 16'h2831, rx[0]);
      check("capture two wire", 16'h9200, rx[1]);
      step(16'h4852, 2);
      check("mu-law capture", 16'had00, rx[1]);
      check("rate", 1, rateSelect);
      step(16'h4873, 2);
      check("a-law capture", 16'h8700, rx[2]);
      apb(0, 12'h008, 0); check("unmapped", 1, err);
      check("unmapped data", 0, rd);
      giveVerdict;
   end
endmodule
